// [core/pew_params.svh]
// Purpose: timing and layout constants for the page-write memory host
// Assumes: 20 MHz clock, 50 ns period
// Notes:   waits round up, only the byte-load limit rounds down
`ifndef PEW_PARAMS_SVH
`define PEW_PARAMS_SVH

`define PEW_CLK_NS       50
`define PEW_CYC_UP(t)    (((t) + `PEW_CLK_NS - 1) / `PEW_CLK_NS)
`define PEW_CYC_DN(t)    ((t) / `PEW_CLK_NS)

// ---------------------------------------------------------------
// field layout
// ---------------------------------------------------------------
`define PEW_AW           13
`define PEW_DW           8
`define PEW_PAGE_LSB     4
`define PEW_PAGE_BYTES   16
`define PEW_POLL_BIT     7

// ---------------------------------------------------------------
// times and derived cycle counts
// ---------------------------------------------------------------
`define PEW_T_ACC_NS     450
`define PEW_T_OHZ_NS     100
`define PEW_T_WP_NS      150
`define PEW_T_BLC_US     20
`define PEW_T_WC_MS      10
`define PEW_SYNC         2
`define PEW_ACC_CYC      `PEW_CYC_UP(`PEW_T_ACC_NS)
`define PEW_REC_CYC      `PEW_CYC_UP(`PEW_T_OHZ_NS)
`define PEW_WP_CYC       `PEW_CYC_UP(`PEW_T_WP_NS)
`define PEW_BLC_CYC      `PEW_CYC_DN(`PEW_T_BLC_US * 1000)
`define PEW_BLC_LIM      (`PEW_BLC_CYC - 4)
`define PEW_WC_CYC       `PEW_CYC_UP(`PEW_T_WC_MS * 1000000)
`define PEW_TW           9
`define PEW_WCW          18

`endif

// [core/pew_pkg.sv]
// Purpose: types for the page-write memory host
// Assumes: pew_params.svh constants
// Notes:   whole controller state is one packed struct
`include "pew_params.svh"

package pew_pkg;

  typedef enum logic [8:0] {
    PEW_IDLE     = 9'h001,
    PEW_RD_ACT   = 9'h002,
    PEW_RD_REC   = 9'h004,
    PEW_WR_SET   = 9'h008,
    PEW_WR_PULSE = 9'h010,
    PEW_WR_HOLD  = 9'h020,
    PEW_PAGE     = 9'h040,
    PEW_POLL_ACT = 9'h080,
    PEW_POLL_REC = 9'h100
  } pew_state_t;

  typedef struct packed {
    pew_state_t             st;
    logic [`PEW_TW-1:0]     cnt;
    logic [`PEW_TW-1:0]     pt;
    logic [`PEW_WCW-1:0]    wc;
    logic [4:0]             nb;
    logic                   pend;
    logic                   cur_wr;
    logic                   cur_last;
    logic [`PEW_AW-1:0]     cur_addr;
    logic [`PEW_DW-1:0]     cur_data;
    logic [`PEW_AW-1:0]     lst_addr;
    logic                   lst_d7;
    logic                   samp7;
    logic [`PEW_DW-1:0]     s1;
    logic [`PEW_DW-1:0]     s2;
    logic                   ce_n;
    logic                   oe_n;
    logic                   we_n;
    logic [`PEW_AW-1:0]     addr;
    logic [`PEW_DW-1:0]     dout;
    logic                   doe;
    logic                   ready;
    logic                   rsp_v;
    logic [`PEW_DW-1:0]     rsp_d;
    logic                   rsp_to;
  } pew_regs_t;

endpackage

// [core/pew_host.sv]
// Purpose: host controller driving a byte-wide page-write nonvolatile memory
// Assumes: 20 MHz clock; memory pins are asynchronous to it
// Notes:   writes are grouped into pages, completion found by top-bit polling
//
// Operation
// R1 - read runs while select and drive low
// R2 - memory floats data unless both low
// R3 - write needs select, strobe low, drive high
// R4 - address taken at later falling edge
// R5 - data taken at earlier rising edge
// R6 - programming completes without host action
// R7 - programming lasts at most 10 ms
// R8 - without polling wait 10 ms
// R9 - two to sixteen loads per page; host also closes a page after a single load when cmd_last is set
// R10 - page bits 4..12 unchanged within page
// R11 - extra loads reuse first cycle form
// R12 - next load within 20 us
// R13 - 20 us silence closes the page
// R14 - busy read inverts top bit
// R15 - finished read shows true top bit
// R16 - poll is ordinary read timing
// R17 - drive may pulse between loads
// R18 - each load is complete write cycle
// R19 - strobe pulses under 20 ns ignored
// R20 - drive low or strobe high inhibits
// R21 - select high means standby
// R22 - thirteen address lines pick one byte
// R23 - write mode pin combination, standby floats
// R24 - writes ignored while programming
// R25 - low address bits pick page slot
`include "pew_params.svh"
`timescale 1ns/1ps
`default_nettype none

module pew_host #(
  parameter int unsigned WC_CYC = `PEW_WC_CYC
) (
  input  wire logic                clock,
  input  wire logic                rst,
  input  wire logic                cmd_valid,
  input  wire logic                cmd_write,
  input  wire logic                cmd_last,
  input  wire logic [`PEW_AW-1:0]  cmd_addr,
  input  wire logic [`PEW_DW-1:0]  cmd_wdata,
  output var  logic                cmd_ready,
  output var  logic                rsp_valid,
  output var  logic [`PEW_DW-1:0]  rsp_rdata,
  output var  logic                rsp_timeout,
  output var  logic                mem_ce_n,
  output var  logic                mem_oe_n,
  output var  logic                mem_we_n,
  output var  logic [`PEW_AW-1:0]  address_lines,
  output var  logic [`PEW_DW-1:0]  data_lines_out,
  output var  logic                data_lines_oe,
  input  wire logic [`PEW_DW-1:0]  data_lines_in
);
  import pew_pkg::*;

  pew_regs_t state_r;
  pew_regs_t state_nxt;
  logic      poll_bit_line;

  assign poll_bit_line = state_r.s2[`PEW_POLL_BIT];

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb
  begin
    state_nxt       = state_r;
    state_nxt.s1    = data_lines_in;
    state_nxt.s2    = state_r.s1;
    state_nxt.rsp_v = 1'b0;

    case (state_r.st)
      PEW_IDLE:
      begin
        if (cmd_valid && state_r.ready)
        begin
          state_nxt.cur_wr   = cmd_write;
          state_nxt.cur_last = cmd_last;
          state_nxt.cur_addr = cmd_addr;
          state_nxt.cur_data = cmd_wdata;
          state_nxt.st       = cmd_write ? PEW_WR_SET : PEW_RD_ACT;
        end
      end
      PEW_RD_ACT:
      begin
        // data pins are resynchronised, so sampling waits two extra cycles
        if (state_r.cnt == `PEW_TW'(`PEW_ACC_CYC + `PEW_SYNC)) // R1
        begin
          state_nxt.rsp_d  = state_r.s2;
          state_nxt.rsp_to = 1'b0;
          state_nxt.rsp_v  = 1'b1;
          state_nxt.st     = PEW_RD_REC;
        end
      end
      PEW_RD_REC:
      begin
        // let the memory release the bus before we may drive it
        if (state_r.cnt == `PEW_TW'(`PEW_REC_CYC - 1)) // R2
          state_nxt.st = PEW_IDLE;
      end
      PEW_WR_SET:
        state_nxt.st = PEW_WR_PULSE; // R3
      PEW_WR_PULSE:
      begin
        // pulse far wider than the noise filter
        if (state_r.cnt == `PEW_TW'(`PEW_WP_CYC - 1)) // R19
          state_nxt.st = PEW_WR_HOLD;
      end
      PEW_WR_HOLD:
      begin
        state_nxt.nb       = 5'(state_r.nb + 5'h1); // R9
        state_nxt.lst_addr = state_r.cur_addr;
        state_nxt.lst_d7   = state_r.cur_data[`PEW_POLL_BIT];
        if (state_r.cur_last || state_nxt.nb == 5'(`PEW_PAGE_BYTES))
          state_nxt.st = PEW_POLL_ACT;
        else
          state_nxt.st = PEW_PAGE;
      end
      PEW_PAGE:
      begin
        if (cmd_valid && state_r.ready)
        begin
          state_nxt.cur_wr   = cmd_write;
          state_nxt.cur_last = cmd_last;
          state_nxt.cur_addr = cmd_addr;
          state_nxt.cur_data = cmd_wdata;
          if (cmd_write && cmd_addr[`PEW_AW-1:`PEW_PAGE_LSB] ==
              state_r.lst_addr[`PEW_AW-1:`PEW_PAGE_LSB]) // R10
            state_nxt.st = PEW_WR_SET; // R11
          else
          begin
            // other page or a read: close this page first, run it afterwards
            state_nxt.pend = 1'b1; // R24
            state_nxt.st   = PEW_POLL_ACT;
          end
        end
        else if (!state_r.ready)
          state_nxt.st = PEW_POLL_ACT; // R13
      end
      PEW_POLL_ACT:
      begin
        if (state_r.cnt == `PEW_TW'(`PEW_ACC_CYC + `PEW_SYNC)) // R16
        begin
          state_nxt.samp7 = poll_bit_line;
          state_nxt.st    = PEW_POLL_REC;
        end
      end
      PEW_POLL_REC:
      begin
        if (state_r.cnt == `PEW_TW'(`PEW_REC_CYC - 1))
        begin
          if (state_r.samp7 == state_r.lst_d7 || state_r.wc >= `PEW_WCW'(WC_CYC)) // R14 R15 R8
          begin
            state_nxt.rsp_v  = 1'b1;
            state_nxt.rsp_to = state_r.samp7 != state_r.lst_d7; // R7
            state_nxt.nb     = 5'h0;
            state_nxt.pend   = 1'b0;
            if (!state_r.pend)
              state_nxt.st = PEW_IDLE;
            else if (state_r.cur_wr)
              state_nxt.st = PEW_WR_SET;
            else
              state_nxt.st = PEW_RD_ACT;
          end
          else
            state_nxt.st = PEW_POLL_ACT;
        end
      end
      default:
        state_nxt.st = PEW_IDLE;
    endcase

    // ---------------------------------------------------------------
    // counters
    // ---------------------------------------------------------------
    state_nxt.cnt = (state_nxt.st != state_r.st) ? '0 : `PEW_TW'(state_r.cnt + `PEW_TW'(1));
    if (state_nxt.st == PEW_WR_PULSE && state_r.st != PEW_WR_PULSE)
      state_nxt.pt = '0; // R12
    else if (state_r.pt != '1)
      state_nxt.pt = `PEW_TW'(state_r.pt + `PEW_TW'(1));
    if (state_r.st == PEW_POLL_ACT || state_r.st == PEW_POLL_REC)
    begin
      if (state_r.wc != '1)
        state_nxt.wc = `PEW_WCW'(state_r.wc + `PEW_WCW'(1));
    end
    else
      state_nxt.wc = '0;

    // ---------------------------------------------------------------
    // pins follow the next state, so they leave flops directly
    // ---------------------------------------------------------------
    state_nxt.ce_n = 1'b1; // R21
    state_nxt.oe_n = 1'b1; // R20
    state_nxt.we_n = 1'b1;
    state_nxt.doe  = 1'b0;
    case (state_nxt.st)
      PEW_RD_ACT, PEW_POLL_ACT:
      begin
        state_nxt.ce_n = 1'b0;
        state_nxt.oe_n = 1'b0;
        state_nxt.addr = (state_nxt.st == PEW_RD_ACT) ? state_nxt.cur_addr : state_nxt.lst_addr; // R22
      end
      PEW_WR_SET:
      begin
        // address set a cycle before the strobe, data held through release
        state_nxt.ce_n = 1'b0; // R23
        state_nxt.addr = state_nxt.cur_addr; // R25
        state_nxt.dout = state_nxt.cur_data;
        state_nxt.doe  = 1'b1;
      end
      PEW_WR_PULSE:
      begin
        state_nxt.ce_n = 1'b0;
        state_nxt.we_n = 1'b0; // R4
        state_nxt.doe  = 1'b1;
      end
      PEW_WR_HOLD:
        state_nxt.doe = 1'b1; // R5 R18
      default:
        state_nxt.doe = 1'b0;
    endcase

    // page stays open only while the next strobe can still fall in time
    state_nxt.ready = (state_nxt.st == PEW_IDLE) ||
                      (state_nxt.st == PEW_PAGE && state_nxt.pt < `PEW_TW'(`PEW_BLC_LIM) &&
                       state_nxt.nb < 5'(`PEW_PAGE_BYTES)); // R6 R17
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      state_r      <= '0;
      state_r.st   <= PEW_IDLE;
      state_r.ce_n <= 1'b1;
      state_r.oe_n <= 1'b1;
      state_r.we_n <= 1'b1;
    end
    else
      state_r <= state_nxt;
  end

  assign cmd_ready      = state_r.ready;
  assign rsp_valid      = state_r.rsp_v;
  assign rsp_rdata      = state_r.rsp_d;
  assign rsp_timeout    = state_r.rsp_to;
  assign mem_ce_n       = state_r.ce_n;
  assign mem_oe_n       = state_r.oe_n;
  assign mem_we_n       = state_r.we_n;
  assign address_lines  = state_r.addr;
  assign data_lines_out = state_r.dout;
  assign data_lines_oe  = state_r.doe;

endmodule

`default_nettype wire

// [verification/pew_mem_model.sv]
// Purpose: behavioural page-write memory on the host pins
// Assumes: pins asynchronous; data lines have no pull
// Notes:   slow stretches programming past the host poll limit
`timescale 1ns/1ps
`default_nettype none
module pew_mem_model #(parameter int BLC_NS = 20000) (
  input  wire logic        ce_n,
  input  wire logic        oe_n,
  input  wire logic        we_n,
  input  wire logic        slow,
  input  wire logic [12:0] addr,
  input  wire logic [7:0]  din,
  output var  logic [7:0]  dq
);
  logic [7:0]  mem [8192];
  logic [7:0]  pb [16];
  logic [15:0] ld = '0;
  logic [12:0] la = '0;
  logic        busy = 1'b0;
  logic        arm = 1'b0;
  logic        d7 = 1'b0;
  int          seq = 0;
  time         t0 = 0;
  wire         wr_on = !ce_n && !we_n && oe_n;
  initial
    for (int i = 0; i < 8192; i++)
      mem[i] = i[7:0] ^ 8'h5A;
  // ----
  // address at the later fall, data at the earlier rise
  // ----
  always @(posedge wr_on)
  begin
    t0 = $time;
    if (!busy)
    begin
      arm = 1'b1;
      la = addr;
      seq = seq + 1;
      fork
        close_page(seq);
      join_none
    end
  end
  // only a strobe that was seen to start may load; the fall out of the
  // unknown power-up pin state must not
  always @(negedge wr_on)
  begin
    if (arm && !busy && $time - t0 >= 20)
    begin
      pb[la[3:0]] = din;
      ld[la[3:0]] = 1'b1;
      d7 = din[7];
    end
    arm = 1'b0;
  end
  task automatic close_page(input int n);
    #(BLC_NS);
    if (n == seq && ld != '0)
    begin
      busy = 1'b1;
      #(slow ? 150000 : 5000);
      for (int i = 0; i < 16; i++)
        if (ld[i])
          mem[{la[12:4], i[3:0]}] = pb[i];
      ld = '0;
      busy = 1'b0;
    end
  endtask
  // released lines toggle so a stale byte never looks valid
  always @(ce_n, oe_n, addr, busy, ld)
    if (!ce_n && !oe_n)
      dq = (busy || ld != '0) && addr == la ? {~d7, mem[addr][6:0]} : mem[addr];
    else
      dq = ~dq;
endmodule
`default_nettype wire

// [verification/pew_host_sva.sv]
// Purpose: port checks for the memory host
// Assumes: one clock, rst async high
// Notes:   po marks a loaded page not yet answered
`timescale 1ns/1ps
`default_nettype none
module pew_host_sva #(parameter int unsigned WC_CYC = 50) (
  input wire logic        clock,
  input wire logic        rst,
  input wire logic        cmd_valid,
  input wire logic        cmd_write,
  input wire logic        cmd_ready,
  input wire logic [12:0] cmd_addr,
  input wire logic        rsp_valid,
  input wire logic        rsp_timeout,
  input wire logic        mem_ce_n,
  input wire logic        mem_oe_n,
  input wire logic        mem_we_n,
  input wire logic [12:0] address_lines,
  input wire logic [7:0]  data_lines_out,
  input wire logic        data_lines_oe
);
  logic        po;
  logic [8:0]  gap;
  logic [12:4] pg;
  logic [17:0] wt;
  wire         tk = cmd_valid && cmd_ready;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  always_ff @(posedge clock or posedge rst)
    if (rst)
    begin
      po <= 1'b0;
      gap <= 9'h000;
      pg <= 9'h000;
      wt <= 18'h00000;
    end
    else
    begin
      po <= rsp_valid ? 1'b0 : (po || $fell(mem_we_n));
      gap <= $fell(mem_we_n) ? 9'h000 : gap + 9'h001;
      pg <= $fell(mem_we_n) ? address_lines[12:4] : pg;
      wt <= po ? wt + 18'h00001 : 18'h00000;
    end
  a_rd_latency: assert property (tk && !cmd_write && !po |-> ##13 rsp_valid)
    else $error("read answer late");
  a_rd_pins: assert property (tk && !cmd_write && !po |=> address_lines == $past(cmd_addr)
    && !mem_ce_n && !mem_oe_n && mem_we_n && !data_lines_oe) else $error("read pins wrong");
  a_no_contend: assert property (!mem_oe_n |-> !data_lines_oe && mem_we_n)
    else $error("bus contention");
  a_wr_mode: assert property (!mem_we_n |-> !mem_ce_n && mem_oe_n && data_lines_oe)
    else $error("bad write pins");
  a_wr_pulse: assert property ($fell(mem_we_n) |-> (!mem_we_n && $stable(address_lines)
    && $stable(data_lines_out))[*3] ##1 (mem_we_n && $stable(address_lines))) else $error("strobe");
  a_page_same: assert property ($fell(mem_we_n) && po |-> address_lines[12:4] == pg
    && gap < 9'h190) else $error("page load wrong");
  a_rd_recover: assert property ($rose(mem_oe_n) |-> (mem_ce_n && mem_oe_n && mem_we_n)[*2])
    else $error("no recovery");
  a_wc_bound: assert property (po |-> wt < WC_CYC + 440)
    else $error("write never answered");
  c_timeout: cover property (rsp_valid && rsp_timeout);
  c_page_load: cover property ($fell(mem_we_n) && po);
  c_read: cover property (tk && !cmd_write && !po);
endmodule
bind pew_host pew_host_sva #(.WC_CYC(WC_CYC)) u_pew_host_sva (.clock, .rst, .cmd_valid, .cmd_write,
  .cmd_ready, .cmd_addr, .rsp_valid, .rsp_timeout, .mem_ce_n, .mem_oe_n, .mem_we_n, .address_lines,
  .data_lines_out, .data_lines_oe);
`default_nettype wire

// [verification/pew_host_tb_top.sv]
// Purpose: self-checking bench for the memory host
// Assumes: 20 MHz clock, model memory on the pins
// Notes:   poll limit shortened so a slow program times out
`timescale 1ns/1ps
`default_nettype none
module pew_host_tb_top;
  typedef struct packed {logic rd; logic to; logic [7:0] d;} pew_exp_t;
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic        cmd_valid = 1'b0;
  logic        cmd_write = 1'b0;
  logic        cmd_last = 1'b0;
  logic        slow = 1'b0;
  logic [12:0] cmd_addr = 13'h0000;
  logic [7:0]  cmd_wdata = 8'h00;
  logic        cmd_ready, rsp_valid, rsp_timeout, ce_n, oe_n, we_n, lines_oe;
  logic [12:0] address_lines, pg;
  logic [7:0]  rsp_rdata, lines_out, dq, bus, d, o;
  logic [7:0]  ref_m [8192];
  pew_exp_t    q [$];
  pew_exp_t    e;
  int          n_mismatch = 0;
  int          tests_run = 0;
  assign bus = lines_oe ? lines_out : dq;
  always #25 clock = ~clock;
  pew_host #(.WC_CYC(2000)) u_pew_host (.clock, .rst, .cmd_valid, .cmd_write, .cmd_last, .cmd_addr,
    .cmd_wdata, .cmd_ready, .rsp_valid, .rsp_rdata, .rsp_timeout, .mem_ce_n(ce_n), .mem_oe_n(oe_n),
    .mem_we_n(we_n), .address_lines, .data_lines_out(lines_out), .data_lines_oe(lines_oe),
    .data_lines_in(bus));
  pew_mem_model u_pew_mem_model (.ce_n, .oe_n, .we_n, .slow, .addr(address_lines), .din(bus), .dq);
  task finish_test;
    if (n_mismatch == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task cmd(input logic w, input logic l, input logic [12:0] a, input logic [7:0] v);
    int k;
    @(negedge clock);
    {cmd_valid, cmd_write, cmd_last, cmd_addr, cmd_wdata} = {1'b1, w, l, a, v};
    for (k = 0; k < 5000 && cmd_ready !== 1'b1; k++)
      @(negedge clock);
    if (cmd_ready !== 1'b1)
    begin
      n_mismatch++;
      finish_test;
    end
    @(negedge clock);
    cmd_valid = 1'b0;
  endtask
  task drain;
    int k;
    for (k = 0; k < 20000 && q.size() != 0; k++)
      @(negedge clock);
    if (q.size() != 0)
    begin
      n_mismatch++;
      finish_test;
    end
  endtask
  task rd(input logic [12:0] a, input logic [7:0] x);
    q.push_back({1'b1, 1'b0, x});
    cmd(1'b0, 1'b0, a, 8'h00);
  endtask
  task wr(input logic [12:0] a, input logic [7:0] v, input logic l);
    ref_m[a] = v;
    if (l)
      q.push_back({1'b0, slow, 8'h00});
    cmd(1'b1, l, a, v);
  endtask
  task cmp_rd(input logic [7:0] x);
    tests_run++;
    if (rsp_rdata !== x || rsp_timeout !== 1'b0)
    begin
      n_mismatch++;
      $display("MISMATCH %0t got %h exp %h", $time, rsp_rdata, x);
    end
  endtask
  task cmp_done(input logic x);
    tests_run++;
    if (rsp_timeout !== x)
    begin
      n_mismatch++;
      $display("MISMATCH %0t got %h exp %h", $time, rsp_timeout, x);
    end
  endtask
  // ----
  // watcher pairs each answer with the oldest note
  // ----
  always @(negedge clock)
    if (rsp_valid === 1'b1)
    begin
      if (q.size() == 0)
      begin
        n_mismatch++;
        $display("MISMATCH %0t got %h exp %h", $time, rsp_valid, 1'b0);
      end
      else
      begin
        e = q.pop_front();
        if (e.rd)
          cmp_rd(e.d);
        else
          cmp_done(e.to);
      end
    end
  initial
  begin
    void'($urandom(12));
    for (int i = 0; i < 8192; i++)
      ref_m[i] = i[7:0] ^ 8'h5A;
    repeat (16) @(posedge clock);
    @(negedge clock);
    rst = 1'b0;
    rd(13'h0000, ref_m[0]);
    rd(13'h1FFF, ref_m[8191]);
    pg = 13'($urandom) & 13'h1FF0;
    for (int i = 0; i < 16; i++)
      wr(pg | 13'(i), 8'($urandom), i == 15);
    for (int i = 0; i < 16; i++)
      rd(pg | 13'(i), ref_m[pg | 13'(i)]);
    pg = pg ^ 13'h0100;
    for (int i = 0; i < 3; i++)
      wr(pg | 13'(i * 5), 8'($urandom), 1'b0);
    q.push_back(10'h000); // a read closes the open page first
    rd(pg | 13'h1, ref_m[pg | 13'h1]);
    rd(pg | 13'hA, ref_m[pg | 13'hA]);
    q.push_back(10'h000);
    wr(pg | 13'hF, 8'h80, 1'b0);
    drain;
    rd(pg | 13'hF, 8'h80);
    slow = 1'b1;
    d = 8'($urandom);
    o = ref_m[13'h1042];
    wr(13'h1042, d, 1'b1);
    drain;
    rd(13'h1042, {~d[7], o[6:0]});
    drain;
    finish_test;
  end
endmodule
`default_nettype wire
